/* src/wemt_wake_ctrl.sv */
// Wake source masking, edge selection, routing and hibernation timer
// Notes on behaviour
// - Group 4 mask bits 7,6,4,3,2 block their sources; bits 5,1,0 reserved.
// - Group 5 mask has eight read/write bits, one per source 10..17.
// - Group 6 mask has eight bits for sources 20..27, kept read/write.
// - Group 7 mask: bit 5 serial done, bits 1,0 fans; others reserved.
// - Group 8 mask: bits 3..0 low-voltage pins; upper four bits reserved.
// - Hibernation timer is an 8-bit down-counter in 30-second steps.
// - At zero the timer stops, holds zero and raises a wake event.
// - Timer advances only on the 32 kHz clock.
// - Writing a non-zero value loads the timer and starts counting.
// - Edge field: 00 falling, 01 rising, 10 either, 11 reserved.
// - Selectable sources 04, 06, 07 drive external interrupt line 2.
// - Sources 10, 12, 13, 15..17 drive external interrupt line 3.
// - Sources 20..23 and 25..27 drive external interrupt line 4.
// - Reprogramming an edge field may leave a spurious status bit.
// - Masked sources still set status but raise no interrupt; masks reset clear.
// - Status bits read one while set and clear only on write-one.
`timescale 1ns/1ns
module wemt_wake_ctrl #(
    parameter int HIB_STEP_TICKS = wemt_pkg::HIB_STEP_TICKS,
    parameter int PRESC_W = $clog2(HIB_STEP_TICKS)
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [23:0] selectable_wake_source_i,
    input wire logic serial_periph_complete_wake_i,
    input wire logic first_fan_speed_wake_i,
    input wire logic second_fan_speed_wake_i,
    input wire logic [3:0] low_volt_pin_wake_i,
    input wire logic slow_clk_32k_i,
    output logic core_ext_irq_line_2_o,
    output logic core_ext_irq_line_3_o,
    output logic core_ext_irq_line_4_o,
    output logic aux_wake_irq_o,
    output logic hib_wake_o
);

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic [7:0] mask4_r;
    logic [7:0] mask5_r;
    logic [7:0] mask6_r;
    logic [7:0] mask7_r;
    logic [7:0] mask8_r;
    logic [7:0] esel_r [0:5];
    logic [23:0] stat_sel_r;
    logic [23:0] stat_sel_nxt;
    logic [6:0] stat_fix_r;
    logic [6:0] stat_fix_nxt;
    logic [7:0] reg_rdata_r;
    logic [7:0] rd_mux;
    logic [7:0] hib_cnt_r;
    logic [7:0] hib_cnt_nxt;
    logic [PRESC_W-1:0] presc_r;
    logic slow_s1_r;
    logic slow_s2_r;
    logic slow_prev_r;
    wemt_pkg::wemt_hib_state_t hib_state_r;
    wemt_pkg::wemt_hib_state_t hib_state_nxt;

    // Register write decode
    wire wr_mask4 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_MASK4);
    wire wr_mask5 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_MASK5);
    wire wr_mask6 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_MASK6);
    wire wr_mask7 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_MASK7);
    wire wr_mask8 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_MASK8);
    wire wr_stat4 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_STAT4);
    wire wr_stat5 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_STAT5);
    wire wr_stat6 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_STAT6);
    wire wr_stat7 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_STAT7);
    wire wr_stat8 = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_STAT8);
    wire wr_hib = reg_wr_i & hit(reg_addr_i, wemt_pkg::OFS_HIBCNT);
    wire wr_hib_go = wr_hib & (reg_wdata_i != 8'h00);

    // Edge select registers, six bytes addressed by index
    genvar gi;
    generate
        for (gi = 0; gi < wemt_pkg::NUM_ESEL; gi++)
        begin : g_esel
            wire wr_esel = reg_wr_i & hit(reg_addr_i, wemt_pkg::ESEL_OFS[gi]);
            // New select applies at once; software clears any stray status
            always_ff @(posedge ref_clk_i)
            begin
                if (rst_i)
                    esel_r[gi] <= wemt_pkg::REG_RESET;
                else if (wr_esel)
                    esel_r[gi] <= reg_wdata_i & wemt_pkg::ESEL_WM[gi];
            end
        end
    endgenerate

    wire [47:0] sel_fields = {esel_r[5], esel_r[4], esel_r[3], esel_r[2], esel_r[1], esel_r[0]};

    // Edge qualification of selectable sources
    logic [23:0] sel_edge;
    wemt_edge_detect #(
        .N(wemt_pkg::NUM_SEL)
    ) u_sel_edge (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(selectable_wake_source_i),
        .sel_i(sel_fields),
        .edge_o(sel_edge)
    );

    // Fixed sources wake on assertion only
    logic [6:0] fix_edge;
    wire [6:0] fix_pins = {low_volt_pin_wake_i, serial_periph_complete_wake_i,
                           second_fan_speed_wake_i, first_fan_speed_wake_i};
    wemt_edge_detect #(
        .N(wemt_pkg::NUM_FIXED)
    ) u_fix_edge (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(fix_pins),
        .sel_i({wemt_pkg::NUM_FIXED{wemt_pkg::EDGE_RISE}}),
        .edge_o(fix_edge)
    );

    // Mask registers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            mask4_r <= wemt_pkg::REG_RESET;
            mask5_r <= wemt_pkg::REG_RESET;
            mask6_r <= wemt_pkg::REG_RESET;
            mask7_r <= wemt_pkg::REG_RESET;
            mask8_r <= wemt_pkg::REG_RESET;
        end
        else
        begin
            if (wr_mask4)
                mask4_r <= reg_wdata_i & wemt_pkg::WM_MASK4;
            if (wr_mask5)
                mask5_r <= reg_wdata_i & wemt_pkg::WM_FULL;
            // Printed as write-one-clear, which makes no sense for a mask
            if (wr_mask6)
                mask6_r <= reg_wdata_i & wemt_pkg::WM_FULL;
            if (wr_mask7)
                mask7_r <= reg_wdata_i & wemt_pkg::WM_MASK7;
            if (wr_mask8)
                mask8_r <= reg_wdata_i & wemt_pkg::WM_MASK8;
        end
    end

    wire [23:0] sel_mask = {mask6_r, mask5_r, mask4_r};
    wire [6:0] fix_mask = {mask8_r[3:0], mask7_r[wemt_pkg::ST7_SPI_BIT],
                           mask7_r[wemt_pkg::ST7_FAN2_BIT], mask7_r[wemt_pkg::ST7_FAN1_BIT]};

    // Sticky status; a new edge beats a same-cycle clear
    wire [23:0] sel_clr = {wr_stat6 ? reg_wdata_i : 8'h00, wr_stat5 ? reg_wdata_i : 8'h00,
                           wr_stat4 ? reg_wdata_i : 8'h00};
    wire [6:0] fix_clr = {wr_stat8 ? reg_wdata_i[3:0] : 4'h0,
                          wr_stat7 & reg_wdata_i[wemt_pkg::ST7_SPI_BIT],
                          wr_stat7 & reg_wdata_i[wemt_pkg::ST7_FAN2_BIT],
                          wr_stat7 & reg_wdata_i[wemt_pkg::ST7_FAN1_BIT]};
    wire [23:0] sel_valid = {wemt_pkg::WM_FULL, wemt_pkg::WM_FULL, wemt_pkg::WM_MASK4};

    assign stat_sel_nxt = ((stat_sel_r & ~sel_clr) | sel_edge) & sel_valid;
    assign stat_fix_nxt = (stat_fix_r & ~fix_clr) | fix_edge;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            stat_sel_r <= '0;
            stat_fix_r <= '0;
        end
        else
        begin
            stat_sel_r <= stat_sel_nxt;
            stat_fix_r <= stat_fix_nxt;
        end
    end

    // Interrupt routing of unmasked pending status
    wire [23:0] sel_pend = stat_sel_r & ~sel_mask;
    wire [6:0] fix_pend = stat_fix_r & ~fix_mask;
    assign core_ext_irq_line_2_o = |(sel_pend & wemt_pkg::ROUTE_IRQ2);
    assign core_ext_irq_line_3_o = |(sel_pend & wemt_pkg::ROUTE_IRQ3);
    assign core_ext_irq_line_4_o = |(sel_pend & wemt_pkg::ROUTE_IRQ4);
    // Sources on no external line still need a way to wake the core
    wire [23:0] route_any = wemt_pkg::ROUTE_IRQ2 | wemt_pkg::ROUTE_IRQ3 | wemt_pkg::ROUTE_IRQ4;
    assign aux_wake_irq_o = (|(sel_pend & ~route_any)) | (|fix_pend);

    // Slow clock is sampled, not used as a clock; one domain only
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            slow_s1_r <= 1'b0;
            slow_s2_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end
        else
        begin
            slow_s1_r <= slow_clk_32k_i;
            slow_s2_r <= slow_s1_r;
            slow_prev_r <= slow_s2_r;
        end
    end

    wire slow_rise = slow_s2_r & ~slow_prev_r;
    wire step_tick = slow_rise & (presc_r == PRESC_W'(HIB_STEP_TICKS - 1));

    // Prescaler restarts on each load so the first step is a full 30 s
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || wr_hib)
            presc_r <= '0;
        else if (step_tick)
            presc_r <= '0;
        else if (slow_rise)
            presc_r <= presc_r + PRESC_W'(1);
    end

    // Hibernation timer state
    always_comb
    begin
        hib_state_nxt = hib_state_r;
        hib_cnt_nxt = hib_cnt_r;
        case (hib_state_r)
            wemt_pkg::HIB_IDLE:
            begin
                if (wr_hib_go)
                begin
                    hib_state_nxt = wemt_pkg::HIB_RUN;
                    hib_cnt_nxt = reg_wdata_i;
                end
            end
            wemt_pkg::HIB_RUN:
            begin
                if (wr_hib)
                begin
                    hib_cnt_nxt = reg_wdata_i;
                    hib_state_nxt = wr_hib_go ? wemt_pkg::HIB_RUN : wemt_pkg::HIB_IDLE;
                end
                else if (step_tick)
                begin
                    hib_cnt_nxt = hib_cnt_r - 8'h01;
                    if (hib_cnt_r == wemt_pkg::HIB_LAST)
                        hib_state_nxt = wemt_pkg::HIB_DONE;
                end
            end
            wemt_pkg::HIB_DONE:
            begin
                if (wr_hib)
                begin
                    hib_cnt_nxt = reg_wdata_i;
                    hib_state_nxt = wr_hib_go ? wemt_pkg::HIB_RUN : wemt_pkg::HIB_IDLE;
                end
            end
            default:
            begin
                hib_state_nxt = wemt_pkg::HIB_IDLE;
                hib_cnt_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            hib_state_r <= wemt_pkg::HIB_IDLE;
            hib_cnt_r <= wemt_pkg::REG_RESET;
        end
        else
        begin
            hib_state_r <= hib_state_nxt;
            hib_cnt_r <= hib_cnt_nxt;
        end
    end

    // Wake level holds until software rewrites the count
    assign hib_wake_o = (hib_state_r == wemt_pkg::HIB_DONE);

    // Read mux, answered one cycle after the read strobe
    always_comb
    begin
        case (reg_addr_i)
            wemt_pkg::OFS_MASK4: rd_mux = mask4_r;
            wemt_pkg::OFS_MASK5: rd_mux = mask5_r;
            wemt_pkg::OFS_MASK6: rd_mux = mask6_r;
            wemt_pkg::OFS_MASK7: rd_mux = mask7_r;
            wemt_pkg::OFS_MASK8: rd_mux = mask8_r;
            wemt_pkg::OFS_ESEL4A: rd_mux = esel_r[0];
            wemt_pkg::OFS_ESEL4B: rd_mux = esel_r[1];
            wemt_pkg::OFS_ESEL5A: rd_mux = esel_r[2];
            wemt_pkg::OFS_ESEL5B: rd_mux = esel_r[3];
            wemt_pkg::OFS_ESEL6A: rd_mux = esel_r[4];
            wemt_pkg::OFS_ESEL6B: rd_mux = esel_r[5];
            wemt_pkg::OFS_STAT4: rd_mux = stat_sel_r[7:0];
            wemt_pkg::OFS_STAT5: rd_mux = stat_sel_r[15:8];
            wemt_pkg::OFS_STAT6: rd_mux = stat_sel_r[23:16];
            wemt_pkg::OFS_STAT7: rd_mux = {2'h0, stat_fix_r[2], 3'h0, stat_fix_r[1:0]};
            wemt_pkg::OFS_STAT8: rd_mux = {4'h0, stat_fix_r[6:3]};
            wemt_pkg::OFS_HIBCNT: rd_mux = hib_cnt_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            reg_rdata_r <= wemt_pkg::REG_RESET;
        else if (reg_rd_i)
            reg_rdata_r <= rd_mux;
    end

    assign reg_rdata_o = reg_rdata_r;

    property p_mask4_rsvd;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_mask4 |=> (mask4_r == ($past(reg_wdata_i) & wemt_pkg::WM_MASK4));
    endproperty
    a_mask4_rsvd: assert property (p_mask4_rsvd) else $error("mask4 write wrong");

    property p_mask5_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_mask5 |=> (mask5_r == $past(reg_wdata_i))
            ##1 (mask5_r == $past(mask5_r) || $past(wr_mask5));
    endproperty
    a_mask5_write: assert property (p_mask5_write) else $error("mask5 not held");

    property p_mask6_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_mask6 |=> mask6_r == $past(reg_wdata_i);
    endproperty
    a_mask6_write: assert property (p_mask6_write) else $error("mask6 not written");

    property p_mask78_rsvd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mask7_r & ~wemt_pkg::WM_MASK7) == 8'h00 && (mask8_r & ~wemt_pkg::WM_MASK8) == 8'h00;
    endproperty
    a_mask78_rsvd: assert property (p_mask78_rsvd) else $error("reserved mask bit set");

    property p_hib_load;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_hib_go |=> hib_cnt_r == $past(reg_wdata_i) && hib_state_r == wemt_pkg::HIB_RUN;
    endproperty
    a_hib_load: assert property (p_hib_load) else $error("timer did not load");

    property p_hib_step;
        @(posedge ref_clk_i) disable iff (rst_i)
        step_tick && !wr_hib && hib_state_r == wemt_pkg::HIB_RUN
            |=> hib_cnt_r == $past(hib_cnt_r) - 8'h01;
    endproperty
    a_hib_step: assert property (p_hib_step) else $error("timer did not step");

    property p_hib_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        hib_wake_o && !wr_hib |=> hib_wake_o && hib_cnt_r == 8'h00;
    endproperty
    a_hib_hold: assert property (p_hib_hold) else $error("expired timer moved");

    property p_masked_quiet;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mask5_r == wemt_pkg::WM_FULL) |-> !core_ext_irq_line_3_o;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked source fired");

    property p_irq2_cause;
        @(posedge ref_clk_i) disable iff (rst_i)
        sel_edge[4] && !mask4_r[4] |=> core_ext_irq_line_2_o;
    endproperty
    a_irq2_cause: assert property (p_irq2_cause) else $error("line 2 missed edge");

    property p_stat_sticky;
        @(posedge ref_clk_i) disable iff (rst_i)
        !wr_stat5 |=> (stat_sel_r[15:8] & $past(stat_sel_r[15:8])) == $past(stat_sel_r[15:8]);
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("status lost");

endmodule : wemt_wake_ctrl

/* src/wemt_pkg.sv */
// Constants and types shared by the wake qualification block
package wemt_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register offsets in the core's memory-mapped space
    localparam logic [15:0] OFS_STAT8 = 16'h7f55;
    localparam logic [15:0] OFS_MASK8 = 16'h7f56;
    localparam logic [15:0] OFS_ESEL4A = 16'h7f57;
    localparam logic [15:0] OFS_ESEL4B = 16'h7f58;
    localparam logic [15:0] OFS_STAT4 = 16'h7f59;
    localparam logic [15:0] OFS_MASK4 = 16'h7f5a;
    localparam logic [15:0] OFS_ESEL5A = 16'h7f5c;
    localparam logic [15:0] OFS_ESEL5B = 16'h7f5d;
    localparam logic [15:0] OFS_STAT5 = 16'h7f5e;
    localparam logic [15:0] OFS_MASK5 = 16'h7f5f;
    localparam logic [15:0] OFS_ESEL6A = 16'h7f61;
    localparam logic [15:0] OFS_ESEL6B = 16'h7f62;
    localparam logic [15:0] OFS_STAT6 = 16'h7f63;
    localparam logic [15:0] OFS_STAT7 = 16'h7f64;
    localparam logic [15:0] OFS_MASK7 = 16'h7f65;
    localparam logic [15:0] OFS_MASK6 = 16'h7f66;
    localparam logic [15:0] OFS_HIBCNT = 16'h7ff3;

    localparam int NUM_ESEL = 6;
    localparam logic [15:0] ESEL_OFS [0:5] = '{16'h7f57, 16'h7f58, 16'h7f5c,
                                                16'h7f5d, 16'h7f61, 16'h7f62};

    // Writable bit masks; other bits are reserved and read zero
    localparam logic [7:0] WM_FULL = 8'hff;
    localparam logic [7:0] WM_MASK4 = 8'hdc;
    localparam logic [7:0] WM_MASK7 = 8'h23;
    localparam logic [7:0] WM_MASK8 = 8'h0f;
    localparam logic [7:0] ESEL_WM [0:5] = '{8'hf0, 8'hf3, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] REG_RESET = 8'h00;

    // Selectable sources: index 8*group+n, group 0 = SE0n, 1 = SE1n, 2 = SE2n
    localparam int NUM_SEL = 24;
    localparam logic [23:0] ROUTE_IRQ2 = 24'h0000d0;
    localparam logic [23:0] ROUTE_IRQ3 = 24'h00ed00;
    localparam logic [23:0] ROUTE_IRQ4 = 24'hef0000;

    // Fixed sources: fan1, fan2, serial done, low-voltage pins 0..3
    localparam int NUM_FIXED = 7;
    localparam int NUM_LV = 4;
    localparam int ST7_FAN1_BIT = 0;
    localparam int ST7_FAN2_BIT = 1;
    localparam int ST7_SPI_BIT = 5;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_ANY = 2'h2,
        EDGE_RSVD = 2'h3
    } wemt_edge_t;

    // Hibernation timer
    localparam int HIB_CNT_W = 8;
    localparam int HIB_STEP_S = 30;
    localparam int SLOW_CLK_HZ = 32768;
    localparam int HIB_STEP_TICKS = HIB_STEP_S * SLOW_CLK_HZ;
    localparam logic [7:0] HIB_LAST = 8'h01;

    typedef enum logic [2:0] {
        HIB_IDLE = 3'h1,
        HIB_RUN = 3'h2,
        HIB_DONE = 3'h4
    } wemt_hib_state_t;

endpackage : wemt_pkg

/* src/wemt_edge_detect.sv */
// Synchroniser and per-source edge qualifier
`timescale 1ns/1ns
module wemt_edge_detect #(
    parameter int N = 24
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] pin_i,
    input wire logic [2*N-1:0] sel_i,
    output logic [N-1:0] edge_o
);

    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [N-1:0] prev_r;
    logic [N-1:0] edge_r;
    logic [2:0] arm_r;
    logic [N-1:0] hit;

    function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
        case (sel)
            wemt_pkg::EDGE_FALL: edge_hit = prv & ~cur;
            wemt_pkg::EDGE_RISE: edge_hit = ~prv & cur;
            wemt_pkg::EDGE_ANY: edge_hit = prv ^ cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_hit
            assign hit[gi] = arm_r[2] & edge_hit(sel_i[2*gi+1 -: 2], prev_r[gi], sync2_r[gi]);
        end
    endgenerate

    // Arming hides the reset-to-level step as a false edge
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
            edge_r <= '0;
            arm_r <= '0;
        end
        else
        begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            edge_r <= hit;
            arm_r <= {arm_r[1:0], 1'b1};
        end
    end

    assign edge_o = edge_r;

endmodule : wemt_edge_detect

/* verif/wemt_core_model.sv */
// Embedded core model: byte access to the memory-mapped registers
`timescale 1ns/1ns
module wemt_core_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [15:0] reg_addr_o = 16'h0000,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0,
    output logic [7:0] reg_wdata_o = 8'h00
);
    // Address and data turned over after the strobe, never left stale
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask : rd
endmodule : wemt_core_model

/* verif/wake_event_mask_edge_timer_bench.sv */
// Self-checking bench for the wake qualification block
`timescale 1ns/1ns
module wake_event_mask_edge_timer_bench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic slow_clk = 1'b0;
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [23:0] sel_pin = 24'hffffff;
    logic [6:0] fix_pin = 7'h00;
    logic irq2;
    logic irq3;
    logic irq4;
    logic aux;
    logic hib;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    localparam logic [15:0] OFS [0:11] = '{16'h7f56, 16'h7f57, 16'h7f58, 16'h7f5a,
        16'h7f5c, 16'h7f5d, 16'h7f5f, 16'h7f61, 16'h7f62, 16'h7f65, 16'h7f66, 16'h7ff3};
    localparam logic [7:0] WMSK [0:11] = '{8'h0f, 8'hf0, 8'hf3, 8'hdc, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h23, 8'hff, 8'hff};

    always #25 ref_clk_i = ~ref_clk_i;
    // Slow clock far slower than the bus clock, as the sampler needs
    always #500 slow_clk = ~slow_clk;

    wemt_wake_ctrl #(.HIB_STEP_TICKS(4)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .selectable_wake_source_i(sel_pin),
        .serial_periph_complete_wake_i(fix_pin[6]), .first_fan_speed_wake_i(fix_pin[0]),
        .second_fan_speed_wake_i(fix_pin[1]), .low_volt_pin_wake_i(fix_pin[5:2]),
        .slow_clk_32k_i(slow_clk), .core_ext_irq_line_2_o(irq2),
        .core_ext_irq_line_3_o(irq3), .core_ext_irq_line_4_o(irq4),
        .aux_wake_irq_o(aux), .hib_wake_o(hib));
    wemt_core_model i_core (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_core.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rchk
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wt
    function automatic logic [7:0] irqs();
        return {4'h0, aux, irq2, irq3, irq4};
    endfunction : irqs

    // Reset values, reserved bits and an unmapped hole
    task automatic t_regs();
        chk("irq after reset", 8'h00, irqs() | {7'h0, hib});
        for (int i = 0; i < 12; i++) rchk(OFS[i], 8'h00);
        i_core.wr(16'h7f5b, 8'hff);
        rchk(16'h7f5b, 8'h00);
        for (int i = 0; i < 12; i++) i_core.wr(OFS[i], 8'hff);
        for (int i = 0; i < 12; i++) rchk(OFS[i], WMSK[i]);
        for (int i = 0; i < 12; i++) i_core.wr(OFS[i], 8'h00);
    endtask : t_regs

    // Falling edge under the reset select lands on one line only
    task automatic t_route(input int b, input logic [15:0] st, input logic [7:0] e);
        @(posedge ref_clk_i);
        sel_pin[b] <= 1'b0;
        wt(6);
        chk("irq lines", e, irqs());
        rchk(st, 8'(1 << (b % 8)));
        i_core.wr(st, 8'(1 << (b % 8)));
        wt(1);
        chk("irq cleared", 8'h00, irqs());
        @(posedge ref_clk_i);
        sel_pin[b] <= 1'b1;
        wt(6);
        rchk(st, 8'h00);
    endtask : t_route

    task automatic t_mask();
        i_core.wr(16'h7f5f, 8'h01);
        @(posedge ref_clk_i);
        sel_pin[8] <= 1'b0;
        wt(6);
        chk("masked irq", 8'h00, irqs());
        rchk(16'h7f5e, 8'h01);
        i_core.wr(16'h7f5f, 8'h00);
        wt(1);
        chk("unmasked irq", 8'h02, irqs());
        i_core.wr(16'h7f5e, 8'h01);
        @(posedge ref_clk_i);
        sel_pin[8] <= 1'b1;
        fix_pin <= 7'h01;
        wt(6);
        chk("fan irq", 8'h08, irqs());
        rchk(16'h7f64, 8'h01);
        i_core.wr(16'h7f64, 8'h01);
        i_core.wr(16'h7f56, 8'h01);
        @(posedge ref_clk_i);
        fix_pin <= 7'h05;
        wt(6);
        chk("low volt masked", 8'h00, irqs());
        rchk(16'h7f55, 8'h01);
        @(posedge ref_clk_i);
        fix_pin <= 7'h47;
        wt(6);
        chk("serial and fan2 irq", 8'h08, irqs());
        rchk(16'h7f64, 8'h22);
        i_core.wr(16'h7f64, 8'h22);
        i_core.wr(16'h7f55, 8'h01);
        wt(1);
        chk("fixed irq cleared", 8'h00, irqs());
        i_core.wr(16'h7f56, 8'h00);
    endtask : t_mask

    // Every select code, each edge direction separately
    task automatic t_edge();
        for (int c = 0; c < 4; c++)
        begin
            i_core.wr(16'h7f61, 8'(c));
            i_core.wr(16'h7f63, 8'hff);
            @(posedge ref_clk_i);
            sel_pin[16] <= 1'b0;
            wt(6);
            rchk(16'h7f63, (c == 0 || c == 2) ? 8'h01 : 8'h00);
            i_core.wr(16'h7f63, 8'hff);
            @(posedge ref_clk_i);
            sel_pin[16] <= 1'b1;
            wt(6);
            rchk(16'h7f63, (c == 1 || c == 2) ? 8'h01 : 8'h00);
        end
        i_core.wr(16'h7f63, 8'hff);
    endtask : t_edge

    // Step of 4 slow rises, 20 bus cycles each
    task automatic t_hib();
        i_core.wr(16'h7ff3, 8'h02);
        wt(110);
        rchk(16'h7ff3, 8'h01);
        chk("wake early", 8'h00, {7'h0, hib});
        wt(90);
        chk("wake", 8'h01, {7'h0, hib});
        wt(60);
        rchk(16'h7ff3, 8'h00);
        i_core.wr(16'h7ff3, 8'h00);
        wt(1);
        chk("wake cleared", 8'h00, {7'h0, hib});
    endtask : t_hib

    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wt(4);
        t_regs();
        t_route(4, 16'h7f59, 8'h04);
        t_route(14, 16'h7f5e, 8'h02);
        t_route(16, 16'h7f63, 8'h01);
        t_route(20, 16'h7f63, 8'h08);
        t_route(2, 16'h7f59, 8'h08);
        t_mask();
        t_edge();
        t_hib();
        test_done();
    end
endmodule : wake_event_mask_edge_timer_bench
